/* design/word_exchange_pkg.sv */
// Purpose: constants and carriers for the fieldbus discrete word exchange
// Assumes: one clock, registers reached through the four exchange words
// Notes: bit positions below index the 16-bit exchange words
package word_exchange_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 7;
  localparam logic [6:0] RACK_ADDR_MAX = 7'h7E;
  localparam logic [6:0] RACK_ADDR_RST = 7'h00;
  localparam int SEL_LSB = 0;
  localparam int BIT_LOAD_TARE = 3;
  localparam int BIT_CLR_TARE = 4;
  localparam int BIT_PB_TARE = 5;
  localparam int BIT_PRINT = 6;
  localparam int BIT_ZERO = 7;
  localparam int BIT_SP_EN = 8;
  localparam int BIT_PAR_OUT_LSB = 12;
  localparam int BIT_LOAD_SP = 15;
  localparam int ST_SP1 = 0;
  localparam int ST_SP2 = 1;
  localparam int ST_ZTOL = 2;
  localparam int ST_PAR_IN = 9;
  localparam int ST_MOTION = 12;
  localparam int ST_NET = 13;
  localparam int ST_UPD = 14;
  localparam int ST_OK = 15;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [2:0] {
    SRC_GROSS = 3'h0,
    SRC_NET = 3'h1,
    SRC_DISP = 3'h2,
    SRC_TARE = 3'h3,
    SRC_SP1 = 3'h4
  } src_sel_e;

  typedef enum logic [1:0] {
    NV_IDLE = 2'b00,
    NV_PEND = 2'b01,
    NV_WRITE = 2'b11
  } nv_state_e;

  // live scale data coming from the terminal core
  typedef struct packed {
    logic signed [15:0] gross_disp;
    logic signed [15:0] gross_div;
    logic signed [15:0] net_disp;
    logic signed [15:0] net_div;
    logic signed [15:0] shown_disp;
    logic signed [15:0] shown_div;
    logic signed [15:0] tare_disp;
    logic signed [15:0] tare_div;
    logic signed [15:0] target;
  } scale_data_s;

  typedef struct packed {
    logic over_under_mode;
    logic sp1;
    logic sp2;
    logic ztol;
    logic under;
    logic tol_ok;
    logic over;
    logic motion;
    logic net_mode;
    logic range_err;
    logic powering_up;
    logic expanded;
    logic setup_mode;
    logic indicator_mode;
    logic tare_interlock;
    logic gross_zero;
  } scale_status_s;

  typedef struct packed {
    logic clear_tare;
    logic pb_tare;
    logic print;
    logic zero;
  } cmd_pulse_s;
endpackage

/* design/word_exchange.sv */
// Purpose: discrete word exchange between weighing terminal and fieldbus master
// Assumes: protocol engine writes output words and reads input words synchronously
// Notes: all state frozen while ce_i is low
`timescale 1ns/1ps
module word_exchange
  import word_exchange_pkg::*;
#(
  parameter int RACK_ADDR_DEFAULT = 0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic weight_format_setting_i,
  input wire logic [6:0] rack_address_setting_i,
  input wire logic rack_address_load_i,
  output logic [6:0] rack_address_o,
  input wire logic out_wr_i,
  input wire logic [15:0] out_word0_i,
  input wire logic [15:0] out_word1_i,
  input wire logic in_rd_i,
  input wire logic mem_updating_i,
  output logic [15:0] in_word0_o,
  output logic [15:0] in_word1_o,
  input wire scale_data_s scale_i,
  input wire scale_status_s status_i,
  input wire logic parallel_input_line_i,
  output cmd_pulse_s cmd_o,
  output logic tare_load_o,
  output logic [15:0] preset_tare_o,
  output logic [15:0] setpoint_o,
  output logic setpoint_outputs_en_o,
  output logic nv_commit_o,
  output logic [15:0] nv_setpoint_o,
  output logic parallel_output_first_o,
  output logic parallel_output_second_o,
  output logic parallel_output_third_o
);

  // refused at elaboration: the address register never accepts an address above 126 (RACK_ADDR_MAX)
  if (RACK_ADDR_DEFAULT < 0 || RACK_ADDR_DEFAULT > 126) begin : g_bad_rack_default
    $error("rack address default out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // output words held from the master, and the other registered state
  logic [15:0] w0_q;
  logic [15:0] w1_q;
  logic [15:0] w1_prev_q;
  logic [6:0] rack_q;
  logic [2:0] par_q;
  logic [15:0] tare_q;
  logic [15:0] sp_q;
  logic [15:0] nv_q;
  logic nv_commit_q;
  logic upd_q;
  logic tare_load_q;
  cmd_pulse_s cmd_q;
  nv_state_e nv_q_st, nv_d_st;

  // rising edges of command bits; only new 0-to-1 steps act
  wire [15:0] rise_w = w1_q & ~w1_prev_q;
  wire tare_present_w = (scale_i.tare_div != 16'sh0000);
  wire pb_tare_ok_w = !(status_i.tare_interlock && tare_present_w);
  wire clr_tare_ok_w = !status_i.tare_interlock || status_i.gross_zero;
  wire preset_ok_w = pb_tare_ok_w;
  wire data_ok_w = !(status_i.range_err || status_i.powering_up ||
                     status_i.expanded || status_i.setup_mode);
  wire [2:0] sel_w = w1_q[SEL_LSB +: 3];
  wire rack_ok_w = (rack_address_setting_i <= RACK_ADDR_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // weight source selection, format per setting
  function automatic logic [15:0] pick_fmt(input logic fmt, input logic [15:0] disp,
                                           input logic [15:0] div);
    pick_fmt = fmt ? div : disp;
  endfunction

  logic [15:0] weight_w;
  always_comb begin
    case (sel_w)
      SRC_NET: weight_w = pick_fmt(weight_format_setting_i, scale_i.net_disp, scale_i.net_div);
      SRC_DISP: weight_w = pick_fmt(weight_format_setting_i, scale_i.shown_disp, scale_i.shown_div);
      SRC_TARE: weight_w = status_i.over_under_mode ? scale_i.target :
                           pick_fmt(weight_format_setting_i, scale_i.tare_disp, scale_i.tare_div);
      SRC_SP1: weight_w = sp_q;
      default: weight_w = pick_fmt(weight_format_setting_i, scale_i.gross_disp, scale_i.gross_div);
    endcase
  end

  logic [15:0] status_w;
  always_comb begin
    status_w = WORD_RST;
    status_w[ST_SP1] = status_i.over_under_mode ? status_i.under : status_i.sp1;
    status_w[ST_SP2] = status_i.over_under_mode ? status_i.tol_ok : status_i.sp2;
    status_w[ST_ZTOL] = status_i.over_under_mode ? status_i.over : status_i.ztol;
    status_w[ST_PAR_IN] = parallel_input_line_i;
    status_w[ST_MOTION] = status_i.motion;
    status_w[ST_NET] = status_i.net_mode;
    status_w[ST_UPD] = upd_q;
    status_w[ST_OK] = data_ok_w;
  end

  ////////////////////////////////////////////////////////////////////////////
  // non-volatile setpoint commit: waits for enable after a download
  always_comb begin
    nv_d_st = nv_q_st;
    case (nv_q_st)
      NV_IDLE: if (rise_w[BIT_LOAD_SP]) nv_d_st = NV_PEND;
      NV_PEND: if (w1_q[BIT_SP_EN]) nv_d_st = NV_WRITE;
      NV_WRITE: nv_d_st = rise_w[BIT_LOAD_SP] ? NV_PEND : NV_IDLE;
      default: nv_d_st = NV_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w0_q <= WORD_RST;
      w1_q <= WORD_RST;
      w1_prev_q <= WORD_RST;
    end else if (ce_i) begin
      if (out_wr_i) begin
        w0_q <= out_word0_i;
        w1_q <= out_word1_i;
      end
      w1_prev_q <= w1_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rack_q <= RACK_ADDR_RST;
    end else if (ce_i && rack_address_load_i && rack_ok_w) begin
      rack_q <= rack_address_setting_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= '0;
      tare_load_q <= 1'b0;
      tare_q <= WORD_RST;
    end else if (ce_i) begin
      cmd_q.clear_tare <= rise_w[BIT_CLR_TARE] && clr_tare_ok_w;
      cmd_q.pb_tare <= rise_w[BIT_PB_TARE] && pb_tare_ok_w;
      cmd_q.print <= rise_w[BIT_PRINT];
      cmd_q.zero <= rise_w[BIT_ZERO];
      tare_load_q <= rise_w[BIT_LOAD_TARE] && preset_ok_w;
      if (rise_w[BIT_LOAD_TARE] && preset_ok_w) tare_q <= w0_q;
    end
  end

  // setpoint kept in primary calibrated unit, no conversion applied
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_q <= WORD_RST;
      nv_q <= WORD_RST;
      nv_commit_q <= 1'b0;
      nv_q_st <= NV_IDLE;
    end else if (ce_i) begin
      nv_q_st <= nv_d_st;
      if (rise_w[BIT_LOAD_SP]) sp_q <= w0_q;
      nv_commit_q <= (nv_d_st == NV_WRITE);
      if (nv_d_st == NV_WRITE) nv_q <= sp_q;
    end
  end

  // output control ignored outside indicator mode; last accepted level held
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_q <= 3'h0;
    end else if (ce_i && status_i.indicator_mode) begin
      par_q <= w1_q[BIT_PAR_OUT_LSB +: 3];
    end
  end

  // update flag: sticky until the master reads; set wins over the clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_q <= 1'b0;
      in_word0_o <= WORD_RST;
      in_word1_o <= WORD_RST;
    end else if (ce_i) begin
      if (in_rd_i && mem_updating_i) upd_q <= 1'b1;
      else if (in_rd_i) upd_q <= 1'b0;
      in_word0_o <= data_ok_w ? weight_w : WORD_RST;
      in_word1_o <= status_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rack_address_o = rack_q;
  assign cmd_o = cmd_q;
  assign tare_load_o = tare_load_q;
  assign preset_tare_o = tare_q;
  assign setpoint_o = sp_q;
  assign setpoint_outputs_en_o = w1_q[BIT_SP_EN];
  assign nv_commit_o = nv_commit_q;
  assign nv_setpoint_o = nv_q;
  assign parallel_output_first_o = par_q[0];
  assign parallel_output_second_o = par_q[1];
  assign parallel_output_third_o = par_q[2];

  ////////////////////////////////////////////////////////////////////////////
  print_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && rise_w[BIT_PRINT] |=> cmd_o.print)
    else $error("print edge lost");
  print_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !rise_w[BIT_PRINT] |=> !cmd_o.print)
    else $error("print without edge");
  tare_copy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && tare_load_o |-> preset_tare_o == $past(w0_q))
    else $error("preset tare mismatch");
  zero_force_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && in_word1_o[ST_OK] == 1'b0 |-> in_word0_o == 16'h0000)
    else $error("weight not zeroed");
  clear_lock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && status_i.tare_interlock && !status_i.gross_zero |=> !cmd_o.clear_tare)
    else $error("clear tare off zero");
  accum_lock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && status_i.tare_interlock && tare_present_w |=> !cmd_o.pb_tare)
    else $error("accumulative tare");
  nv_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    nv_commit_o |-> $past(w1_q[BIT_SP_EN]))
    else $error("commit without enable");
  par_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !status_i.indicator_mode |=> $stable(par_q))
    else $error("outputs changed outside indicator");
  upd_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && in_rd_i && mem_updating_i ##1 ce_i |=> in_word1_o[ST_UPD])
    else $error("update flag missing");
  sp_en_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && out_wr_i |=> setpoint_outputs_en_o == $past(out_word1_i[BIT_SP_EN]))
    else $error("enable mismatch");
endmodule

/* testbench/bus_master.sv */
// Purpose: fieldbus master model driving the exchange words
// Assumes: strobes raised 1 ns after a rising edge, held one cycle
// Notes: reread count is bounded so a stuck update bit cannot hang
`timescale 1ns/1ps
module bus_master (
  input wire logic clk_i,
  input wire logic [15:0] in_word1_i,
  output logic out_wr_o,
  output logic [15:0] w0_o,
  output logic [15:0] w1_o,
  output logic in_rd_o
);
  initial begin
    out_wr_o = 1'b0;
    in_rd_o = 1'b0;
    w0_o = 16'h0000;
    w1_o = 16'h0000;
  end
  task automatic put(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk_i);
    #1;
    out_wr_o = 1'b1;
    w0_o = a;
    w1_o = b;
    @(posedge clk_i);
    #1;
    out_wr_o = 1'b0;
  endtask
  // edge bits are dropped again so that the next command can act
  task automatic cmd(input logic [15:0] a, input logic [15:0] b);
    put(a, b);
    put(a, b & 16'h7107);
  endtask
  task automatic rd(output logic upd1, output int tries);
    tries = 0;
    upd1 = 1'b0;
    do begin
      @(posedge clk_i);
      #1;
      in_rd_o = 1'b1;
      @(posedge clk_i);
      #1;
      in_rd_o = 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      if (tries == 0) upd1 = in_word1_i[14];
      tries++;
    end while (in_word1_i[14] && tries < 4);
  endtask
endmodule

/* testbench/testbench.sv */
// Purpose: self-checking bench for the word exchange
// Assumes: clock enable high except in one freeze test
// Notes: expected weight and status words come from bench functions; other expected values are literals or sp_exp
`timescale 1ns/1ps
module testbench
  import word_exchange_pkg::*;
;
  logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, weight_format_setting_i = 1'b0;
  logic rack_address_load_i = 1'b0, mem_updating_i = 1'b0, parallel_input_line_i = 1'b0;
  logic [6:0] rack_address_setting_i = 7'h00, rack_address_o;
  logic out_wr_i, in_rd_i, tare_load_o, setpoint_outputs_en_o, nv_commit_o, f;
  logic parallel_output_first_o, parallel_output_second_o, parallel_output_third_o;
  logic [15:0] out_word0_i, out_word1_i, in_word0_o, in_word1_o, preset_tare_o, setpoint_o, nv_setpoint_o;
  logic [15:0] sp_exp = 16'h0000;
  scale_data_s scale_i = '0;
  scale_status_s status_i = '0;
  cmd_pulse_s cmd_o;
  int err_count = 0, checks_done = 0, n_tl = 0, n_nv = 0, n;
  int n_cmd [4] = '{0, 0, 0, 0};
  wire ou = status_i.over_under_mode;
  wire data_ok = !(status_i.range_err | status_i.powering_up | status_i.expanded | status_i.setup_mode);
  ////////////////////////////////////////////////////////////////////////
  word_exchange i_dut (.clk_i, .rst_n_i, .ce_i, .weight_format_setting_i, .rack_address_setting_i,
    .rack_address_load_i, .rack_address_o, .out_wr_i, .out_word0_i, .out_word1_i, .in_rd_i,
    .mem_updating_i, .in_word0_o, .in_word1_o, .scale_i, .status_i, .parallel_input_line_i, .cmd_o,
    .tare_load_o, .preset_tare_o, .setpoint_o, .setpoint_outputs_en_o, .nv_commit_o, .nv_setpoint_o,
    .parallel_output_first_o, .parallel_output_second_o, .parallel_output_third_o);
  bus_master i_master (.clk_i, .in_word1_i(in_word1_o), .out_wr_o(out_wr_i), .w0_o(out_word0_i),
    .w1_o(out_word1_i), .in_rd_o(in_rd_i));
  initial forever #25 clk_i = ~clk_i;
  // pulses counted rather than timed, so one missing or extra pulse shows as a wrong count
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) n_cmd[k] += int'(cmd_o[k]);
    n_tl += int'(tare_load_o);
    n_nv += int'(nv_commit_o);
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [15:0] exp_w(input logic [2:0] s);
    logic fm;
    fm = weight_format_setting_i;
    if (!data_ok) return 16'h0000;
    case (s)
      3'h1: return fm ? scale_i.net_div : scale_i.net_disp;
      3'h2: return fm ? scale_i.shown_div : scale_i.shown_disp;
      3'h3: return ou ? scale_i.target : (fm ? scale_i.tare_div : scale_i.tare_disp);
      3'h4: return sp_exp;
      default: return fm ? scale_i.gross_div : scale_i.gross_disp;
    endcase
  endfunction
  function automatic logic [15:0] exp_s();
    return {data_ok, 1'b0, status_i.net_mode, status_i.motion, 2'b00, parallel_input_line_i, 6'h00,
      ou ? status_i.over : status_i.ztol, ou ? status_i.tol_ok : status_i.sp2,
      ou ? status_i.under : status_i.sp1};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(20000);
    err_count++;
    $display("unexpected run length: expected end seen timeout");
    tally_and_finish();
  end
  initial begin
    logic [159:0] r;
    void'($urandom(50));
    tick(3);
    rst_n_i = 1'b1;
    chk("rack address", 16'h0000, {9'h000, rack_address_o});
    for (int i = 0; i < 16; i++) begin
      r = {$urandom, $urandom, $urandom, $urandom, $urandom};
      scale_i = r[143:0];
      status_i = r[159:144];
      if (i < 12) {status_i.range_err, status_i.powering_up, status_i.expanded, status_i.setup_mode} = 4'h0;
      weight_format_setting_i = i[3];
      parallel_input_line_i = 1'($urandom);
      i_master.put(16'h0000, {13'h0000, i[2:0]});
      tick(3);
      chk("weight word", exp_w(i[2:0]), in_word0_o);
      chk("status word", exp_s(), in_word1_o);
    end
    $display("weight and status done");
    status_i = '0;
    for (int b = 0; b < 4; b++) begin
      i_master.put(16'h0000, 16'h0010 << b);
      i_master.cmd(16'h0000, 16'h0010 << b);
      i_master.cmd(16'h0000, 16'h0010 << b);
    end
    status_i.tare_interlock = 1'b1;
    scale_i.tare_div = 16'h0005;
    i_master.cmd(16'h1234, 16'h0038);
    scale_i.tare_div = 16'h0000;
    status_i.gross_zero = 1'b1;
    i_master.cmd(16'h1234, 16'h0038);
    tick(3);
    for (int k = 0; k < 4; k++) chk("command count", (k > 1) ? 16'h0003 : 16'h0002, 16'(n_cmd[k]));
    chk("tare load count", 16'h0001, 16'(n_tl));
    chk("preset tare", 16'h1234, preset_tare_o);
    $display("commands done");
    i_master.cmd(16'hFF21, 16'h8004);
    tick(3);
    sp_exp = 16'hFF21;
    chk("setpoint", sp_exp, setpoint_o);
    chk("weight word", exp_w(3'h4), in_word0_o);
    chk("commit count", 16'h0000, 16'(n_nv));
    i_master.put(16'h0000, 16'h0104);
    tick(3);
    chk("commit count", 16'h0001, 16'(n_nv));
    chk("stored setpoint", sp_exp, nv_setpoint_o);
    chk("setpoint enable", 16'h0001, {15'h0000, setpoint_outputs_en_o});
    $display("setpoint done");
    status_i.indicator_mode = 1'b1;
    i_master.put(16'h0000, 16'h5000);
    tick(3);
    chk("parallel outputs", 16'h0005, {13'h0000, parallel_output_third_o, parallel_output_second_o,
      parallel_output_first_o});
    status_i.indicator_mode = 1'b0;
    i_master.put(16'h0000, 16'h2000);
    tick(3);
    chk("parallel outputs", 16'h0005, {13'h0000, parallel_output_third_o, parallel_output_second_o,
      parallel_output_first_o});
    $display("parallel outputs done");
    // a write offered while frozen must be lost, so no print pulse may follow
    ce_i = 1'b0;
    i_master.put(16'h0000, 16'h0040);
    tick(3);
    ce_i = 1'b1;
    tick(3);
    chk("frozen print count", 16'h0002, 16'(n_cmd[1]));
    $display("clock enable done");
    mem_updating_i = 1'b1;
    fork
      i_master.rd(f, n);
      begin
        tick(4);
        mem_updating_i = 1'b0;
      end
    join
    chk("update flag", 16'h0001, {15'h0000, f});
    chk("read tries", 16'h0002, 16'(n));
    $display("update flag done");
    for (int j = 0; j < 2; j++) begin
      rack_address_setting_i = (j == 0) ? 7'h7E : 7'h7F;
      rack_address_load_i = 1'b1;
      tick(1);
      rack_address_load_i = 1'b0;
      tick(1);
      chk("rack address", 16'h007E, {9'h000, rack_address_o});
    end
    $display("rack address done");
    tally_and_finish();
  end
endmodule
